// ===== shared/flash_read_pkg.sv
// Constants, types and decode helpers for the serial flash read front end.
`default_nettype none
package flash_read_pkg;

	localparam logic [7:0] OP_FAST_READ        = 8'h0B;
	localparam logic [7:0] OP_FAST_READ_WIDE   = 8'h0C;
	localparam logic [7:0] OP_DUAL_OUT_READ    = 8'h3B;
	localparam logic [7:0] OP_DUAL_OUT_WIDE    = 8'h3C;
	localparam logic [7:0] OP_QUAD_OUT_READ    = 8'h6B;
	localparam logic [7:0] OP_QUAD_OUT_WIDE    = 8'h6C;
	localparam logic [7:0] OP_DUAL_IO_READ     = 8'hBB;
	localparam logic [7:0] OP_DUAL_IO_WIDE     = 8'hBC;

	localparam logic [3:0] MODE_KEEP_NIBBLE    = 4'hA;
	localparam logic [5:0] CMD_LAST_CYCLE      = 6'h07;
	localparam logic [5:0] MODE_NIBBLE_CYCLE   = 6'h01;
	localparam logic [5:0] MODE_LAST_CYCLE     = 6'h03;
	localparam logic [5:0] ADDR_LAST_SINGLE3   = 6'h17;
	localparam logic [5:0] ADDR_LAST_SINGLE4   = 6'h1F;
	localparam logic [5:0] ADDR_LAST_DUAL3     = 6'h0B;
	localparam logic [5:0] ADDR_LAST_DUAL4     = 6'h0F;
	localparam int         ADDR_BITS           = 24;
	localparam int         SHIFT_BITS          = 32;

	localparam logic [1:0] LC_NO_LATENCY       = 2'h3;
	localparam logic [5:0] OUT_READ_LATENCY    = 6'h08;
	localparam logic [5:0] DIO_LAT_LC0         = 6'h04;
	localparam logic [5:0] DIO_LAT_LC1         = 6'h04;
	localparam logic [5:0] DIO_LAT_LC2         = 6'h05;
	localparam logic [5:0] DIO_LAT_LC3         = 6'h06;

	localparam int         ARRAY_AW            = 10;
	localparam int         ARRAY_DW            = 8;

	typedef enum logic [2:0] {
		ST_CMD,
		ST_ADDR,
		ST_MODE,
		ST_DUMMY,
		ST_DATA,
		ST_IGNORE
	} frame_state_e;

	typedef enum logic [1:0] {
		K_FAST,
		K_DUAL_OUT,
		K_QUAD_OUT,
		K_DUAL_IO
	} read_kind_e;

	typedef struct packed {
		logic       quad_enable;
		logic [1:0] read_latency_code;
		logic       four_byte_address_select_bit;
	} read_cfg_s;

	typedef struct packed {
		logic [ARRAY_AW-1:0] addr;
		logic [ARRAY_DW-1:0] data;
	} array_load_s;

	typedef struct packed {
		logic       valid;
		read_kind_e kind;
		logic       always_wide;
	} op_dec_s;

	function automatic op_dec_s decode_op(input logic [7:0] op);
		op_dec_s r;
		r = '{valid: 1'b1, kind: K_FAST, always_wide: 1'b0};
		unique case (op)
			OP_FAST_READ:      r.kind = K_FAST;
			OP_FAST_READ_WIDE: begin r.kind = K_FAST; r.always_wide = 1'b1; end
			OP_DUAL_OUT_READ:  r.kind = K_DUAL_OUT;
			OP_DUAL_OUT_WIDE:  begin r.kind = K_DUAL_OUT; r.always_wide = 1'b1; end
			OP_QUAD_OUT_READ:  r.kind = K_QUAD_OUT;
			OP_QUAD_OUT_WIDE:  begin r.kind = K_QUAD_OUT; r.always_wide = 1'b1; end
			OP_DUAL_IO_READ:   r.kind = K_DUAL_IO;
			OP_DUAL_IO_WIDE:   begin r.kind = K_DUAL_IO; r.always_wide = 1'b1; end
			default:           r.valid = 1'b0;
		endcase
		return r;
	endfunction

endpackage
`default_nettype wire

// ===== design/array_mem.sv
// Byte array with a write port on the system clock and a registered read port on the link clock.
`timescale 1ns/1ps
`default_nettype none
module array_mem (
	input  wire logic                                 wr_clock,
	input  wire logic                                 wr_en,
	input  wire flash_read_pkg::array_load_s          wr,
	input  wire logic                                 rd_clock,
	input  wire logic                                 rd_en,
	input  wire logic [flash_read_pkg::ARRAY_AW-1:0]  rd_addr,
	output logic      [flash_read_pkg::ARRAY_DW-1:0]  rd_data
);

	logic [flash_read_pkg::ARRAY_DW-1:0] mem [2**flash_read_pkg::ARRAY_AW];

	// --------------------------------------------------------------
	// Write port.
	// --------------------------------------------------------------
	always_ff @(posedge wr_clock) begin
		if (wr_en) begin
			mem[wr.addr] <= wr.data;
		end
	end

	// --------------------------------------------------------------
	// Registered read port.
	// --------------------------------------------------------------
	always_ff @(posedge rd_clock) begin
		if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end

endmodule
`default_nettype wire

// ===== design/flash_read_front.sv
// Read command front end: decodes reads on the serial link and streams array data out.
`timescale 1ns/1ps
`default_nettype none
module flash_read_front (
	input  wire logic                        clock,
	input  wire logic                        rst_n,
	input  wire flash_read_pkg::read_cfg_s   cfg,
	input  wire logic                        load_valid,
	input  wire flash_read_pkg::array_load_s load,
	output logic                             continuous_read_active,
	input  wire logic                        sck,
	input  wire logic                        cs_n,
	input  wire logic [3:0]                  io_in,
	output logic      [3:0]                  io_out,
	output logic      [3:0]                  io_oe
);

	// --------------------------------------------------------------
	// Declarations.
	// --------------------------------------------------------------
	flash_read_pkg::read_cfg_s    cfg_meta_q;
	flash_read_pkg::read_cfg_s    cfg_sync_q;
	logic                         cont_meta_q;
	logic                         frame_rst_n;

	flash_read_pkg::frame_state_e st_q;
	flash_read_pkg::frame_state_e st_d;
	flash_read_pkg::read_kind_e   kind_q;
	flash_read_pkg::read_kind_e   kind_d;
	logic                         wide_q;
	logic                         wide_d;
	logic [5:0]                   cnt_q;
	logic [5:0]                   cnt_d;
	logic [31:0]                  sh_q;
	logic [31:0]                  sh_d;
	logic [23:0]                  addr_q;
	logic [23:0]                  addr_d;
	logic [2:0]                   slice_q;
	logic [2:0]                   slice_d;

	logic                         keep_q;
	logic                         keep_d;
	logic                         keep_wide_q;
	logic                         keep_wide_d;
	logic                         frame_first;
	logic                         mode_take;
	logic                         mode_keep;

	logic                         rd_en;
	logic [23:0]                  rd_addr;
	logic [7:0]                   rd_data;
	logic [5:0]                   lat_now;
	logic [5:0]                   addr_last;
	logic [2:0]                   slice_last;
	flash_read_pkg::op_dec_s      dec;

	logic [3:0]                   io_out_d;
	logic [3:0]                   io_oe_d;
	logic [7:0]                   rot;

	// --------------------------------------------------------------
	// Decode helpers.
	// --------------------------------------------------------------
	function automatic logic [5:0] latency_of(input flash_read_pkg::read_kind_e k,
		input logic [1:0] lc);
		logic [5:0] r;
		r = flash_read_pkg::OUT_READ_LATENCY;
		if (k == flash_read_pkg::K_DUAL_IO) begin
			unique case (lc)
				2'h0:    r = flash_read_pkg::DIO_LAT_LC0;
				2'h1:    r = flash_read_pkg::DIO_LAT_LC1;
				2'h2:    r = flash_read_pkg::DIO_LAT_LC2;
				default: r = flash_read_pkg::DIO_LAT_LC3;
			endcase
		end else if (lc == flash_read_pkg::LC_NO_LATENCY) begin
			r = 6'h00;
		end
		return r;
	endfunction

	function automatic logic [2:0] slices_of(input flash_read_pkg::read_kind_e k);
		logic [2:0] r;
		unique case (k)
			flash_read_pkg::K_FAST:     r = 3'h7;
			flash_read_pkg::K_QUAD_OUT: r = 3'h1;
			default:                    r = 3'h3;
		endcase
		return r;
	endfunction

	// --------------------------------------------------------------
	// Clock domain crossings.
	// --------------------------------------------------------------
	always_ff @(posedge sck or negedge rst_n) begin
		if (!rst_n) begin
			cfg_meta_q <= '0;
			cfg_sync_q <= '0;
		end else begin
			cfg_meta_q <= cfg;
			cfg_sync_q <= cfg_meta_q;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cont_meta_q            <= 1'b0;
			continuous_read_active <= 1'b0;
		end else begin
			cont_meta_q            <= keep_q;
			continuous_read_active <= cont_meta_q;
		end
	end

	// Frame logic is held in reset whenever the chip is deselected.
	assign frame_rst_n = rst_n & ~cs_n;

	// --------------------------------------------------------------
	// Frame sequencer on the rising link clock edge.
	// --------------------------------------------------------------
	always_comb begin
		st_d        = st_q;
		kind_d      = kind_q;
		wide_d      = wide_q;
		cnt_d       = cnt_q + 6'h01;
		sh_d        = sh_q;
		addr_d      = addr_q;
		slice_d     = slice_q;
		rd_en       = 1'b0;
		rd_addr     = addr_q;
		mode_take   = 1'b0;
		mode_keep   = 1'b0;
		frame_first = (st_q == flash_read_pkg::ST_CMD) && (cnt_q == 6'h00);
		dec         = flash_read_pkg::decode_op({sh_q[6:0], io_in[0]});
		lat_now     = latency_of(kind_q, cfg_sync_q.read_latency_code);
		slice_last  = slices_of(kind_q);
		if (kind_q == flash_read_pkg::K_DUAL_IO) begin
			addr_last = wide_q ? flash_read_pkg::ADDR_LAST_DUAL4 : flash_read_pkg::ADDR_LAST_DUAL3;
		end else begin
			addr_last = wide_q ? flash_read_pkg::ADDR_LAST_SINGLE4 : flash_read_pkg::ADDR_LAST_SINGLE3;
		end
		unique case (st_q)
			flash_read_pkg::ST_CMD: begin
				if (frame_first && keep_q) begin
					// Instruction-less frame: this edge already carries address bits.
					kind_d = flash_read_pkg::K_DUAL_IO;
					wide_d = keep_wide_q;
					sh_d   = {30'h0000_0000, io_in[1:0]};
					st_d   = flash_read_pkg::ST_ADDR;
				end else begin
					sh_d = {sh_q[30:0], io_in[0]};
					if (cnt_q == flash_read_pkg::CMD_LAST_CYCLE) begin
						cnt_d  = 6'h00;
						kind_d = dec.kind;
						wide_d = dec.always_wide | cfg_sync_q.four_byte_address_select_bit;
						if (!dec.valid) begin
							st_d = flash_read_pkg::ST_IGNORE;
						end else if (dec.kind == flash_read_pkg::K_QUAD_OUT
							&& !cfg_sync_q.quad_enable) begin
							st_d = flash_read_pkg::ST_IGNORE;
						end else begin
							st_d = flash_read_pkg::ST_ADDR;
						end
					end
				end
			end
			flash_read_pkg::ST_ADDR: begin
				if (kind_q == flash_read_pkg::K_DUAL_IO) begin
					sh_d = {sh_q[29:0], io_in[1:0]};
				end else begin
					sh_d = {sh_q[30:0], io_in[0]};
				end
				if (cnt_q == addr_last) begin
					cnt_d  = 6'h00;
					addr_d = sh_d[flash_read_pkg::ADDR_BITS-1:0];
					if (kind_q == flash_read_pkg::K_DUAL_IO) begin
						st_d = flash_read_pkg::ST_MODE;
					end else if (lat_now == 6'h00) begin
						st_d    = flash_read_pkg::ST_DATA;
						rd_en   = 1'b1;
						rd_addr = sh_d[flash_read_pkg::ADDR_BITS-1:0];
						slice_d = 3'h0;
					end else begin
						st_d = flash_read_pkg::ST_DUMMY;
					end
				end
			end
			flash_read_pkg::ST_MODE: begin
				sh_d = {sh_q[29:0], io_in[1:0]};
				if (cnt_q == flash_read_pkg::MODE_NIBBLE_CYCLE) begin
					// Only the upper nibble decides; the lower two cycles are not looked at.
					mode_take = 1'b1;
					mode_keep = (sh_d[3:0] == flash_read_pkg::MODE_KEEP_NIBBLE);
				end
				if (cnt_q == flash_read_pkg::MODE_LAST_CYCLE) begin
					cnt_d = 6'h00;
					if (lat_now == 6'h00) begin
						st_d    = flash_read_pkg::ST_DATA;
						rd_en   = 1'b1;
						slice_d = 3'h0;
					end else begin
						st_d = flash_read_pkg::ST_DUMMY;
					end
				end
			end
			flash_read_pkg::ST_DUMMY: begin
				// Input lines are not sampled here.
				if (cnt_q == lat_now - 6'h01) begin
					cnt_d   = 6'h00;
					st_d    = flash_read_pkg::ST_DATA;
					rd_en   = 1'b1;
					slice_d = 3'h0;
				end
			end
			flash_read_pkg::ST_DATA: begin
				cnt_d = cnt_q;
				if (slice_q == slice_last) begin
					addr_d  = addr_q + 24'h00_0001;
					rd_en   = 1'b1;
					rd_addr = addr_q + 24'h00_0001;
					slice_d = 3'h0;
				end else begin
					slice_d = slice_q + 3'h1;
				end
			end
			flash_read_pkg::ST_IGNORE: begin
				cnt_d = cnt_q;
			end
		endcase
	end

	always_ff @(posedge sck or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			st_q    <= flash_read_pkg::ST_CMD;
			kind_q  <= flash_read_pkg::K_FAST;
			wide_q  <= 1'b0;
			cnt_q   <= 6'h00;
			sh_q    <= '0;
			addr_q  <= '0;
			slice_q <= 3'h0;
		end else begin
			st_q    <= st_d;
			kind_q  <= kind_d;
			wide_q  <= wide_d;
			cnt_q   <= cnt_d;
			sh_q    <= sh_d;
			addr_q  <= addr_d;
			slice_q <= slice_d;
		end
	end

	// --------------------------------------------------------------
	// Continuous mode state kept across frames.
	// --------------------------------------------------------------
	always_comb begin
		keep_d      = keep_q;
		keep_wide_d = keep_wide_q;
		if (frame_first && !cs_n) begin
			// Each frame must earn the next instruction-less frame again.
			keep_d = 1'b0;
		end
		if (mode_take) begin
			keep_d      = mode_keep;
			keep_wide_d = wide_q;
		end
	end

	always_ff @(posedge sck or negedge rst_n) begin
		if (!rst_n) begin
			keep_q      <= 1'b0;
			keep_wide_q <= 1'b0;
		end else begin
			keep_q      <= keep_d;
			keep_wide_q <= keep_wide_d;
		end
	end

	// --------------------------------------------------------------
	// Array storage.
	// --------------------------------------------------------------
	array_mem u_array (
		.wr_clock (clock),
		.wr_en    (load_valid),
		.wr       (load),
		.rd_clock (sck),
		.rd_en    (rd_en),
		.rd_addr  (rd_addr[flash_read_pkg::ARRAY_AW-1:0]),
		.rd_data  (rd_data)
	);

	// --------------------------------------------------------------
	// Output drivers on the falling link clock edge.
	// --------------------------------------------------------------
	always_comb begin
		io_out_d = 4'h0;
		io_oe_d  = 4'h0;
		unique case (kind_q)
			flash_read_pkg::K_FAST:     rot = rd_data << slice_q;
			flash_read_pkg::K_QUAD_OUT: rot = rd_data << {slice_q[1:0], 2'b00};
			default:                    rot = rd_data << {slice_q[1:0], 1'b0};
		endcase
		if (st_q == flash_read_pkg::ST_DATA) begin
			unique case (kind_q)
				flash_read_pkg::K_FAST: begin
					io_out_d[1] = rot[7];
					io_oe_d     = 4'h2;
				end
				flash_read_pkg::K_QUAD_OUT: begin
					io_out_d = rot[7:4];
					io_oe_d  = 4'hF;
				end
				default: begin
					io_out_d[1:0] = rot[7:6];
					io_oe_d       = 4'h3;
				end
			endcase
		end
	end

	always_ff @(negedge sck or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			io_out <= 4'h0;
			io_oe  <= 4'h0;
		end else begin
			io_out <= io_out_d;
			io_oe  <= io_oe_d;
		end
	end

endmodule
`default_nettype wire

// ===== verification/flash_read_front_props.sv
// Concurrent checks on the ports of the read front end.
`timescale 1ns/1ps
`default_nettype none
module flash_read_front_props (
	input wire logic                      clock,
	input wire logic                      rst_n,
	input wire flash_read_pkg::read_cfg_s cfg,
	input wire logic                      continuous_read_active,
	input wire logic                      sck,
	input wire logic                      cs_n,
	input wire logic [3:0]                io_in,
	input wire logic [3:0]                io_out,
	input wire logic [3:0]                io_oe
);
	// -----
	// Frame position and captured instruction
	// -----
	logic [6:0] cnt_q;
	logic [6:0] cnt_d;
	logic [7:0] op_q;
	logic [7:0] op_d;
	always_comb begin
		cnt_d = (cnt_q == 7'h7F) ? cnt_q : cnt_q + 7'h01;
		op_d = (cnt_q < 7'h08) ? {op_q[6:0], io_in[0]} : op_q;
	end
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			cnt_q <= 7'h00;
			op_q <= 8'h00;
		end else begin
			cnt_q <= cnt_d;
			op_q <= op_d;
		end
	end
	// -----
	// Assertions
	// -----
	a_deselect_quiet: assert property (@(posedge clock) disable iff (!rst_n)
		cs_n |-> io_oe == 4'h0) else $error("output enabled while deselected");
	a_spare_low: assert property (@(posedge clock) disable iff (!rst_n)
		(io_out & ~io_oe) == 4'h0) else $error("undriven line not low");
	a_cont_set: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(continuous_read_active) |-> !cs_n) else $error("continuous set outside frame");
	a_cont_drop: assert property (@(posedge clock) disable iff (!rst_n)
		$fell(continuous_read_active) |-> !cs_n) else $error("continuous dropped outside frame");
	a_cmd_quiet: assert property (@(posedge sck) disable iff (!rst_n)
		cnt_q <= 7'h08 |-> io_oe == 4'h0) else $error("drive during instruction");
	a_slice_steady: assert property (@(posedge sck) disable iff (!rst_n)
		cnt_q > 7'h08 && $past(io_oe) != 4'h0 |-> io_oe == $past(io_oe))
		else $error("enable changed during data");
	a_fast_start: assert property (@(posedge sck) disable iff (!rst_n)
		cnt_q == 7'h27 && op_q == flash_read_pkg::OP_FAST_READ_WIDE
		&& cfg.read_latency_code == flash_read_pkg::LC_NO_LATENCY
		|-> io_oe == 4'h0 ##1 io_oe == 4'h2) else $error("fast read start wrong");
	a_dual_start: assert property (@(posedge sck) disable iff (!rst_n)
		cnt_q == 7'h27 && op_q == flash_read_pkg::OP_DUAL_OUT_READ
		&& !cfg.four_byte_address_select_bit
		&& cfg.read_latency_code != flash_read_pkg::LC_NO_LATENCY
		|-> io_oe == 4'h0 ##1 io_oe == 4'h3) else $error("dual read start wrong");
	a_quad_refused: assert property (@(posedge sck) disable iff (!rst_n)
		op_q == flash_read_pkg::OP_QUAD_OUT_READ && !cfg.quad_enable
		|-> io_oe == 4'h0) else $error("quad read without enable");
	a_dio_start: assert property (@(posedge sck) disable iff (!rst_n)
		cnt_q == 7'h1B && op_q == flash_read_pkg::OP_DUAL_IO_READ
		&& !cfg.four_byte_address_select_bit && cfg.read_latency_code < 2'h2
		|-> io_oe == 4'h0 ##1 io_oe == 4'h3) else $error("dual io start wrong");
	c_cont: cover property (@(posedge clock) $rose(continuous_read_active));
	c_quad: cover property (@(posedge sck) io_oe == 4'hF);
	c_dio: cover property (@(posedge sck) op_q == flash_read_pkg::OP_DUAL_IO_WIDE && io_oe == 4'h3);
endmodule
bind flash_read_front flash_read_front_props chk (.clock(clock), .rst_n(rst_n), .cfg(cfg),
	.continuous_read_active(continuous_read_active), .sck(sck), .cs_n(cs_n),
	.io_in(io_in), .io_out(io_out), .io_oe(io_oe));
`default_nettype wire

// ===== verification/spi_host_model.sv
// Host controller model that drives the serial link in clock mode 0.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	output logic            sck,
	output logic            cs_n,
	output logic [3:0]      io_in,
	input  wire logic [3:0] io_out,
	output logic            rx_stb,
	output logic [7:0]      rx_byte
);
	logic [3:0] smp;
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		io_in = 4'h0;
		rx_stb = 1'b0;
		rx_byte = 8'h00;
	end
	// One link cycle; released lines toggle instead of holding a value.
	task automatic cyc(input logic [3:0] v, input bit drv);
		io_in = drv ? v : ~io_in;
		#16;
		smp = io_out;
		sck = 1'b1;
		#16;
		sck = 1'b0;
	endtask
	task automatic start();
		cs_n = 1'b0;
	endtask
	task automatic stop();
		#16;
		cs_n = 1'b1;
		io_in = ~io_in;
	endtask
	task automatic send(input logic [31:0] v, input int n, input int w);
		for (int k = n - 1; k >= 0; k--) begin
			cyc(4'((v >> (k * w)) & ((32'h1 << w) - 32'h1)), 1'b1);
		end
	endtask
	task automatic idle(input int n);
		for (int k = 0; k < n; k++) begin
			cyc(4'h0, 1'b0);
		end
	endtask
	task automatic read(input int n, input int w);
		logic [7:0] b;
		for (int i = 0; i < n; i++) begin
			for (int k = 0; k < 8 / w; k++) begin
				cyc(4'h0, 1'b0);
				b = (w == 1) ? {b[6:0], smp[1]} : (w == 2) ? {b[5:0], smp[1:0]} : {b[3:0], smp};
			end
			rx_byte = b;
			rx_stb = ~rx_stb;
		end
	endtask
endmodule
`default_nettype wire

// ===== verification/flash_read_front_tb.sv
// Self-checking bench for the serial flash read front end.
`timescale 1ns/1ps
`default_nettype none
module flash_read_front_tb;
	logic                        clock;
	logic                        rst_n;
	flash_read_pkg::read_cfg_s   cfg;
	logic                        load_valid;
	flash_read_pkg::array_load_s load;
	logic                        cont;
	logic                        sck;
	logic                        cs_n;
	logic [3:0]                  io_in;
	logic [3:0]                  io_out;
	logic [3:0]                  io_oe;
	logic                        rx_stb;
	logic [7:0]                  rx_byte;
	logic [7:0]                  mem [1024];
	logic [7:0]                  exp_q [$];
	logic [3:0]                  hi [4] = '{4'h0, 4'h3, 4'h6, 4'hB};
	logic [31:0]                 seed;
	int                          fails;
	int                          checked;
	int                          cycles;
	bit                          cont_exp;
	flash_read_front dut (.clock(clock), .rst_n(rst_n), .cfg(cfg), .load_valid(load_valid),
		.load(load), .continuous_read_active(cont), .sck(sck), .cs_n(cs_n),
		.io_in(io_in), .io_out(io_out), .io_oe(io_oe));
	spi_host_model host (.sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
		.rx_stb(rx_stb), .rx_byte(rx_byte));
	// -----
	// Helpers
	// -----
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic int lat_of(input logic [1:0] lc);
		case (lc)
			2'h0: return int'(flash_read_pkg::DIO_LAT_LC0);
			2'h1: return int'(flash_read_pkg::DIO_LAT_LC1);
			2'h2: return int'(flash_read_pkg::DIO_LAT_LC2);
			default: return int'(flash_read_pkg::DIO_LAT_LC3);
		endcase
	endfunction
	task automatic err(input string m);
		fails++;
		$display("Error at %0t: %s", $time, m);
	endtask
	task automatic complete_run();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic setcfg(input bit qe, input logic [1:0] lc, input bit ext);
		@(posedge clock);
		cfg <= '{quad_enable: qe, read_latency_code: lc, four_byte_address_select_bit: ext};
		repeat (4) @(posedge clock);
	endtask
	task automatic rd(input logic [7:0] op, input bit cf, input logic [1:0] lc, input bit ext,
		input logic [31:0] a, input logic [7:0] md, input int n);
		bit dio;
		int ab;
		dio = (op[7:4] == 4'hB);
		ab = (ext || op[3:0] == 4'hC) ? 32 : 24;
		setcfg(1'b1, lc, ext);
		for (int i = 0; i < n; i++)
			exp_q.push_back(mem[10'(a + i)]);
		host.start();
		if (!cf)
			host.send(32'(op), 8, 1);
		host.send(a, dio ? ab / 2 : ab, dio ? 2 : 1);
		if (dio) begin
			host.send(32'(md[7:4]), 2, 2);
			host.idle(2 + lat_of(lc));
		end else begin
			host.idle((lc == flash_read_pkg::LC_NO_LATENCY) ? 0 : 8);
		end
		host.read(n, (op[7:4] == 4'h0) ? 1 : (op[7:4] == 4'h6) ? 4 : 2);
		host.idle(3);
		host.stop();
		cont_exp = dio && md[7:4] == flash_read_pkg::MODE_KEEP_NIBBLE;
		repeat (4) @(posedge clock);
		checked++;
		if (cont !== cont_exp) err("continuous flag wrong");
	endtask
	task automatic refuse(input logic [7:0] op);
		setcfg(1'b0, 2'h3, 1'b0);
		host.start();
		host.send(32'(op), 8, 1);
		host.send(rnd(), 24, 1);
		host.idle(16);
		@(posedge clock);
		checked++;
		if (io_oe !== 4'h0) err("refused frame drives lines");
		host.stop();
	endtask
	// -----
	// Checking and stimulus
	// -----
	always @(rx_stb) begin
		if ($time > 0) begin
			checked++;
			if (exp_q.size() == 0)
				err("unexpected byte");
			else if (rx_byte !== exp_q.pop_front())
				err("read data mismatch");
		end
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 60000) begin
			err("timeout");
			complete_run();
		end
	end
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	initial begin
		seed = 32'h0B4F;
		fails = 0;
		checked = 0;
		cycles = 0;
		rst_n = 1'b0;
		cfg = '0;
		load_valid = 1'b0;
		load = '0;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		for (int i = 0; i < 1024; i++) begin
			@(posedge clock);
			mem[i] = 8'(rnd());
			load_valid <= 1'b1;
			load <= '{addr: 10'(i), data: mem[i]};
		end
		@(posedge clock);
		load_valid <= 1'b0;
		$display("test load done");
		for (int h = 0; h < 4; h++)
			for (int l = 0; l < 16; l++)
				rd({hi[h], l[0] ? 4'hC : 4'hB}, 1'b0, 2'(l >> 1), l[3], rnd(), 8'(rnd()) & 8'h5F, 2);
		$display("test command table done");
		rd(8'h0C, 1'b0, 2'h0, 1'b0, 32'h5AFF_FFFE, 8'h00, 4);
		$display("test wrap done");
		rd(8'hBB, 1'b0, 2'h1, 1'b1, rnd(), (8'(rnd()) | 8'hA0) & 8'hAF, 2);
		rd(8'hBB, 1'b1, 2'h1, 1'b1, 32'h0000_0123, 8'hA0, 2);
		rd(8'hBB, 1'b1, 2'h1, 1'b1, 32'h0000_0456, 8'h35, 2);
		rd(8'hBC, 1'b0, 2'h3, 1'b0, rnd(), 8'hA5, 1);
		host.start();
		host.send(32'hFF, 4, 2);
		host.stop();
		repeat (4) @(posedge clock);
		checked++;
		if (cont !== 1'b0) err("short frame kept continuous mode");
		$display("test continuous done");
		refuse(flash_read_pkg::OP_QUAD_OUT_READ);
		refuse(8'h5A);
		$display("test refusal done");
		if (exp_q.size() != 0) err("bytes missing");
		complete_run();
	end
endmodule
`default_nettype wire
